/* File: hdl/lsfl_top.sv */
// limit status flag logic: two out-of-limit status registers and their control
// assumes readings, limits and fault levels arrive synchronous to MCLK
// from measurement engines outside; registers reached over AHB-Lite
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lsfl_top (
  input  wire logic               MCLK,              // system clock
  input  wire logic               RST,               // sync reset, high
  input  wire logic               HSEL,              // slave select
  input  wire logic [31:0]        HADDR,             // byte address
  input  wire logic [1:0]         HTRANS,            // transfer type
  input  wire logic               HWRITE,            // write when high
  input  wire logic [2:0]         HSIZE,             // word only
  input  wire logic [31:0]        HWDATA,            // write data
  input  wire logic               HREADY,            // bus ready
  output logic      [31:0]        HRDATA,            // read data
  output logic                    HREADYOUT,         // slave ready
  output logic                    HRESP,             // always okay
  input  wire logic [4:0][7:0]    VOLT_READING,      // 2.5,core,own,5,12
  input  wire logic [4:0][7:0]    VOLT_LOW,          // low limits
  input  wire logic [4:0][7:0]    VOLT_HIGH,         // high limits
  input  wire logic [2:0][7:0]    TEMP_READING,      // rem1,local,rem2
  input  wire logic [2:0][7:0]    TEMP_LOW,          // low limits
  input  wire logic [2:0][7:0]    TEMP_HIGH,         // high limits
  input  wire logic [2:0][7:0]    TEMP_THERMAL_LIMIT_PIN_LIMIT,  // overtemp limits
  input  wire logic [7:0]         THERMAL_HYSTERESIS,// hysteresis
  input  wire logic [3:0][15:0]   TACH_COUNT,        // period counts
  input  wire logic [3:0][15:0]   TACH_MIN,          // minimum-speed limits
  input  wire logic [2:0]         PWM_OFF,           // pwm output off
  input  wire logic               THERMAL_LIMIT_PIN_TIMER_OVER,  // timer past limit
  input  wire logic [1:0]         DIODE_FAULT,       // open or short
  input  wire logic [5:0]         CORE_VOLTAGE_CODE, // code input levels
  input  wire logic               GENERAL_IO_SIX_IN, // pin level in
  output logic                    GENERAL_IO_SIX_OUT,// pin level out
  output logic                    GENERAL_IO_SIX_OE, // pin driven
  output logic                    FAN_FULL_DUTY,     // force 100% pwm
  output logic                    LIMIT_ALERT        // any flag set
);
  import lsfl_pkg::*;

  // bus address-phase capture
  logic                ap_valid_q, ap_valid_d;   // write pending
  logic [7:0]          ap_idx_q, ap_idx_d;       // pending index
  logic [31:0]         hrdata_q, hrdata_d;       // read data
  logic                hready_q, hready_d;       // ready flop
  logic                hresp_q, hresp_d;         // response flop
  // control registers
  logic [7:0]          cfg1_q, cfg1_d;           // configuration one
  logic [3:0]          mode_q, mode_d;           // pin functions
  logic                gpo_q, gpo_d;             // general output level
  // flags: [6:0] status one, [14:7] status two
  logic [14:0]         flag_q, flag_d;           // sticky flags
  logic [14:0]         cond;                     // present conditions
  logic [14:0]         clr_ok;                   // read may clear
  logic [14:0]         rd_hit;                   // read of flag's register
  // code change window
  logic [11:0]         win_q, win_d;             // window counter
  logic [5:0]          snap_q, snap_d;           // code one window ago
  logic                code_chg;                 // code differs
  // outputs
  logic                gpio_out_q, gpio_out_d;   // pin out level
  logic                gpio_oe_q, gpio_oe_d;     // pin enable
  logic                full_q, full_d;           // full duty
  logic                alert_q, alert_d;         // alert level
  // decode helpers
  logic                accept;                   // address phase taken
  logic                addr_ok;                  // aligned, in range
  logic                rd_s1, rd_s2;             // status reads
  logic                wr_now;                   // write data phase
  logic [7:0]          s2_view;                  // status two readback
  logic [7:0]          s1_view;                  // status one readback
  logic                summary;                  // status two OR
  lsfl_p14_e           p14;                      // multi-function pin use
  logic [4:0]          volt_viol;                // voltage violations
  logic [2:0]          temp_viol;                // temperature violations
  logic [2:0]          ovt_above;                // over overtemp limit
  logic [2:0]          ovt_below;                // under limit minus hyst
  logic [3:0]          fan_viol;                 // slow or stalled

  assign p14 = lsfl_p14_e'(mode_q[LSFL_MODE_P14 +: 2]);

  // voltage comparison per channel
  for (genvar g = 0; g < 5; g++) begin : g_volt
    // strict greater over high, less-or-equal at low
    assign volt_viol[g] = (VOLT_READING[g] > VOLT_HIGH[g]) || (VOLT_READING[g] <= VOLT_LOW[g]);
  end

  // temperature comparison per channel, signed readings
  for (genvar g = 0; g < 3; g++) begin : g_temp
    logic signed [9:0] rd_s;                     // widened reading
    logic signed [9:0] lim_s;                    // widened thermal_limit_pin limit
    logic signed [9:0] hys_s;                    // limit less hysteresis
    assign rd_s  = 10'(signed'(TEMP_READING[g]));
    assign lim_s = 10'(signed'(TEMP_THERMAL_LIMIT_PIN_LIMIT[g]));
    // widened so a large hysteresis cannot wrap
    assign hys_s = lim_s - signed'({2'b00, THERMAL_HYSTERESIS});
    assign temp_viol[g] = (signed'(TEMP_READING[g]) > signed'(TEMP_HIGH[g])) ||
                          (signed'(TEMP_READING[g]) <= signed'(TEMP_LOW[g]));
    assign ovt_above[g] = rd_s > lim_s;
    assign ovt_below[g] = rd_s < hys_s;
  end

  // fan speed check per channel, fan four shares pwm three
  for (genvar g = 0; g < 4; g++) begin : g_fan
    localparam int P = (g == 3) ? 2 : g;         // pwm that drives it
    // longer period count than the minimum means too slow
    assign fan_viol[g] = (TACH_COUNT[g] > TACH_MIN[g]) && !PWM_OFF[P];
  end

  // conditions and clear qualifiers for every flag
  always_comb begin
    cond   = '0;
    clr_ok = '0;
    // status one voltage bits, bit 0 swapped in thermal mode
    cond[0] = mode_q[LSFL_MODE_P22] ? THERMAL_LIMIT_PIN_TIMER_OVER : volt_viol[0];
    cond[3:1] = volt_viol[3:1];
    cond[6:4] = temp_viol;
    // status two bit 0: 12 V rail or code change
    cond[7 + LSFL_S2_RAIL] = mode_q[LSFL_MODE_P21] ? code_chg : volt_viol[4];
    // overtemperature when any channel is over its limit
    cond[7 + LSFL_S2_OVT] = |ovt_above;
    cond[11:9] = fan_viol[2:0];
    // multi-function bit by pin use
    case (p14)
      LSFL_P14_TACH:  cond[7 + LSFL_S2_F4P] = fan_viol[3];
      LSFL_P14_TIMER: cond[7 + LSFL_S2_F4P] = THERMAL_LIMIT_PIN_TIMER_OVER;
      default:        cond[7 + LSFL_S2_F4P] = 1'b0;             // gpio: no flag
    endcase
    cond[14:13] = DIODE_FAULT;
    // a read clears only what has subsided
    clr_ok = ~cond;
    // overtemp needs the hysteresis band cleared on every channel
    clr_ok[7 + LSFL_S2_OVT] = &ovt_below;
  end

  // which flags a read in this cycle reaches
  assign rd_hit = {{8{rd_s2}}, {7{rd_s1}}};

  // sticky flag update, set wins over a read clear
  for (genvar g = 0; g < 15; g++) begin : g_flag
    always_comb begin
      flag_d[g] = cond[g] || (flag_q[g] && !(rd_hit[g] && clr_ok[g]));
      // gpio use: bit holds no event, drop any stale flag
      if (g == 7 + LSFL_S2_F4P && (p14 == LSFL_P14_GPO || p14 == LSFL_P14_GPI)) begin
        flag_d[g] = 1'b0;
      end
    end
  end

  // flag registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      flag_q <= {LSFL_STAT_RST, LSFL_STAT_RST[6:0]};
    end else begin
      flag_q <= flag_d;
    end
  end

  // code compare window: snapshot each 11 us, flag any difference
  always_comb begin
    win_d  = win_q + 12'h001;
    snap_d = snap_q;
    // change seen at a window edge; no history kept inside it
    code_chg = (win_q == LSFL_CODE_LAST) && (CORE_VOLTAGE_CODE != snap_q);
    if (win_q == LSFL_CODE_LAST) begin
      win_d  = 12'h000;
      snap_d = CORE_VOLTAGE_CODE;
    end
  end

  // window registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      win_q  <= 12'h000;
      snap_q <= 6'h00;
    end else begin
      win_q  <= win_d;
      snap_q <= snap_d;
    end
  end

  // readback views
  always_comb begin
    s2_view = flag_q[14:7];
    // summary counts flags only, not a gpio level
    summary = |flag_q[14:7];
    case (p14)
      LSFL_P14_GPO: s2_view[LSFL_S2_F4P] = gpo_q;
      LSFL_P14_GPI: s2_view[LSFL_S2_F4P] = GENERAL_IO_SIX_IN;
      default:      s2_view[LSFL_S2_F4P] = flag_q[7 + LSFL_S2_F4P];
    endcase
    s1_view = {summary, flag_q[6:0]};
  end

  // address decode: aligned word, only the low 1 KB mapped
  assign accept  = HSEL && HTRANS[1] && HREADY;
  assign addr_ok = (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'b00);
  assign rd_s1   = accept && !HWRITE && addr_ok && (HADDR[9:2] == LSFL_IDX_STAT1);
  assign rd_s2   = accept && !HWRITE && addr_ok && (HADDR[9:2] == LSFL_IDX_STAT2);
  assign wr_now  = ap_valid_q;

  // bus slave: zero wait, read data loaded at the address phase
  always_comb begin
    ap_valid_d = accept && HWRITE && addr_ok;
    ap_idx_d   = accept ? HADDR[9:2] : ap_idx_q;
    hready_d   = 1'b1;                           // never stalls
    hresp_d    = 1'b0;                           // always okay
    hrdata_d   = hrdata_q;
    if (accept && !HWRITE) begin
      hrdata_d = 32'h00000000;                   // unmapped reads zero
      if (addr_ok) begin
        case (HADDR[9:2])
          LSFL_IDX_CFG1:  hrdata_d = {24'h000000, cfg1_q};
          LSFL_IDX_STAT1: hrdata_d = {24'h000000, s1_view};
          LSFL_IDX_STAT2: hrdata_d = {24'h000000, s2_view};
          LSFL_IDX_MODE:  hrdata_d = {28'h0000000, mode_q};
          default:        hrdata_d = 32'h00000000;
        endcase
      end
    end
  end

  // bus registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ap_valid_q <= 1'b0;
      ap_idx_q   <= 8'h00;
      hrdata_q   <= 32'h00000000;
      hready_q   <= 1'b1;
      hresp_q    <= 1'b0;
    end else begin
      ap_valid_q <= ap_valid_d;
      ap_idx_q   <= ap_idx_d;
      hrdata_q   <= hrdata_d;
      hready_q   <= hready_d;
      hresp_q    <= hresp_d;
    end
  end

  // register writes in the data phase
  always_comb begin
    cfg1_d = cfg1_q;
    mode_d = mode_q;
    gpo_d  = gpo_q;
    if (wr_now) begin
      case (ap_idx_q)
        LSFL_IDX_CFG1: begin
          // lockable bits frozen once locked; enable always free
          if (cfg1_q[LSFL_CFG_LOCK]) begin
            cfg1_d = (cfg1_q & LSFL_CFG_LOCKABLE) | (HWDATA[7:0] & LSFL_CFG_STORED & ~LSFL_CFG_LOCKABLE);
          end else begin
            cfg1_d = HWDATA[7:0] & LSFL_CFG_STORED;
          end
          // lock is write once: it only ever sets
          cfg1_d[LSFL_CFG_LOCK] = cfg1_q[LSFL_CFG_LOCK] | HWDATA[LSFL_CFG_LOCK];
          cfg1_d[LSFL_CFG_RDY]  = 1'b1;          // ready after reset
        end
        LSFL_IDX_STAT2: begin
          // only the output level is writable, flags ignore writes
          if (p14 == LSFL_P14_GPO) begin
            gpo_d = HWDATA[LSFL_S2_F4P];
          end
        end
        LSFL_IDX_MODE: mode_d = HWDATA[3:0];
        default: cfg1_d = cfg1_q;                // status one ignores writes
      endcase
    end
  end

  // control registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      cfg1_q <= LSFL_CFG1_RST;
      mode_q <= LSFL_MODE_RST;
      gpo_q  <= 1'b0;
    end else begin
      cfg1_q <= cfg1_d;
      mode_q <= mode_d;
      gpo_q  <= gpo_d;
    end
  end

  // pin and protection outputs
  always_comb begin
    gpio_oe_d  = (p14 == LSFL_P14_GPO);
    gpio_out_d = gpo_q && (p14 == LSFL_P14_GPO);
    // fans safe at full duty whenever monitoring is off
    full_d     = !cfg1_q[LSFL_CFG_MON];
    // code change joins the alert like any other flag
    alert_d    = |flag_q;
  end

  // output registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      gpio_oe_q  <= 1'b0;
      gpio_out_q <= 1'b0;
      full_q     <= 1'b1;
      alert_q    <= 1'b0;
    end else begin
      gpio_oe_q  <= gpio_oe_d;
      gpio_out_q <= gpio_out_d;
      full_q     <= full_d;
      alert_q    <= alert_d;
    end
  end

  assign HRDATA             = hrdata_q;
  assign HREADYOUT          = hready_q;
  assign HRESP              = hresp_q;
  assign GENERAL_IO_SIX_OUT = gpio_out_q;
  assign GENERAL_IO_SIX_OE  = gpio_oe_q;
  assign FAN_FULL_DUTY      = full_q;
  assign LIMIT_ALERT        = alert_q;
endmodule
`default_nettype wire

/* File: inc/lsfl_pkg.sv */
// constants, register map and field layout for the limit status flag block
// assumes a 200 MHz system clock and registers reached over an AHB-Lite slave
// Overview of operation
// - status one bits 0-3 flag voltage limits
// - status one bits 4-6 flag temperature limits
// - read clears flag only if condition gone
// - thermal pin mode: bit 0 is timer
// - status one bit 7 ORs status two
// - monitoring enable stays writable after lock
// - monitoring off drives fans full duty
// - status two bit 0 flags 12 V
// - code mode: bit 0 flags code change
// - code change may raise the alert
// - overtemperature clears only below hysteresis
// - fan flags one-three, masked while PWM off
// - fan four flag, masked by PWM three
// - bit 5 is general I/O level
// - timer mode: bit 5 flags timer limit
// - bits 6-7 flag diode faults
// - status registers reset zero, read-only except the status two bit 5 output level in general output mode
// - high is greater, low is less-or-equal
// - fan flag when count exceeds minimum
package lsfl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] LSFL_IDX_CFG1  = 8'h40;
  localparam logic [7:0] LSFL_IDX_STAT1 = 8'h41;
  localparam logic [7:0] LSFL_IDX_STAT2 = 8'h42;
  localparam logic [7:0] LSFL_IDX_MODE  = 8'h80;
  // reset values
  localparam logic [7:0] LSFL_CFG1_RST  = 8'h04;
  localparam logic [7:0] LSFL_STAT_RST  = 8'h00;
  localparam logic [3:0] LSFL_MODE_RST  = 4'h0;
  // configuration one fields
  localparam int LSFL_CFG_MON  = 0;
  localparam int LSFL_CFG_LOCK = 1;
  localparam int LSFL_CFG_RDY  = 2;
  localparam logic [7:0] LSFL_CFG_LOCKABLE = 8'h50;
  localparam logic [7:0] LSFL_CFG_STORED   = 8'h79;
  // pin mode fields
  localparam int LSFL_MODE_P22 = 0;
  localparam int LSFL_MODE_P21 = 1;
  localparam int LSFL_MODE_P14 = 2;
  // status field positions
  localparam int LSFL_S1_SUM  = 7;
  localparam int LSFL_S2_RAIL = 0;
  localparam int LSFL_S2_OVT  = 1;
  localparam int LSFL_S2_F4P  = 5;
  // core voltage code compare window
  localparam int LSFL_CLK_NS      = 5;
  localparam int LSFL_CODE_WIN_NS = 11000;
  localparam int LSFL_CODE_WIN_CYC = LSFL_CODE_WIN_NS / LSFL_CLK_NS;
  localparam logic [11:0] LSFL_CODE_LAST = 12'(LSFL_CODE_WIN_CYC - 1);
  // function of the multi-function pin
  typedef enum logic [1:0] {LSFL_P14_TACH, LSFL_P14_GPO, LSFL_P14_GPI, LSFL_P14_TIMER} lsfl_p14_e;
endpackage

/* File: dv/lsfl_monitor.sv */
// checker for the limit status flag block: bus answers and flag-to-alert links
// assumes it is bound onto lsfl_top, one clock MCLK, synchronous high RST
`timescale 1ns/1ps
`default_nettype none
module lsfl_monitor
  import lsfl_pkg::*;
(
  input wire logic              MCLK,         // clock
  input wire logic              RST,          // sync reset
  input wire logic              HSEL,         // select
  input wire logic [31:0]       HADDR,        // address
  input wire logic [1:0]        HTRANS,       // transfer type
  input wire logic              HWRITE,       // write
  input wire logic              HREADY,       // bus ready
  input wire logic [31:0]       HRDATA,       // read data
  input wire logic              HREADYOUT,    // slave ready
  input wire logic              HRESP,        // response
  input wire logic [4:0][7:0]   VOLT_READING, // voltages
  input wire logic [4:0][7:0]   VOLT_LOW,     // low limits
  input wire logic [4:0][7:0]   VOLT_HIGH,    // high limits
  input wire logic [2:0][7:0]   TEMP_READING, // temperatures
  input wire logic [2:0][7:0]   TEMP_LOW,     // low limits
  input wire logic [3:0][15:0]  TACH_COUNT,   // fan counts
  input wire logic [3:0][15:0]  TACH_MIN,     // fan minimums
  input wire logic [2:0]        PWM_OFF,      // pwm off
  input wire logic [1:0]        DIODE_FAULT,  // diode faults
  input wire logic              LIMIT_ALERT   // alert out
);
  // byte address of status one
  localparam logic [31:0] S1_ADDR = {22'h0, LSFL_IDX_STAT1, 2'b00};
  // any request taken; a read can clear flags, a mode write can mask them
  wire taken = HSEL && HTRANS[1] && HREADY;
  wire c3    = VOLT_READING[3] > VOLT_HIGH[3];
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // read of status one taken at this edge
  sequence rd_s1_s;
    taken && !HWRITE && HADDR == S1_ADDR;
  endsequence
  ready_high_a: assert property (HREADYOUT) else $error("slave inserted a wait");
  resp_okay_a: assert property (!HRESP) else $error("error response seen");
  high_limit_a: assert property (c3 |-> ##[1:3] LIMIT_ALERT) else $error("high limit not flagged");
  low_limit_a: assert property (VOLT_READING[1] <= VOLT_LOW[1] |-> ##[1:3] LIMIT_ALERT)
    else $error("low limit not flagged");
  temp_low_a: assert property ($signed(TEMP_READING[1]) <= $signed(TEMP_LOW[1]) |-> ##[1:3] LIMIT_ALERT)
    else $error("temperature low not flagged");
  fan_slow_a: assert property (TACH_COUNT[0] > TACH_MIN[0] && !PWM_OFF[0] |-> ##[1:3] LIMIT_ALERT)
    else $error("slow fan not flagged");
  diode_alert_a: assert property (DIODE_FAULT[0] |-> ##[1:3] LIMIT_ALERT) else $error("diode fault lost");
  // a mode write masks a flag two edges after it is taken, and the alert follows one edge later
  sticky_alert_a: assert property (LIMIT_ALERT && !taken && !$past(taken) && !$past(taken, 2)
    && !$past(taken, 3) |=> LIMIT_ALERT) else $error("flag dropped without a read");
  persist_read_a: assert property (rd_s1_s ##0 (c3 && $past(c3) && !$past(RST)) |=> HRDATA[3])
    else $error("flag cleared while condition held");
  summary_read_a: assert property (rd_s1_s ##0 (DIODE_FAULT[0] && $past(DIODE_FAULT[0]) && !$past(RST))
    |=> HRDATA[7]) else $error("summary bit missing");
endmodule
bind lsfl_top lsfl_monitor i_lsfl_monitor (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .VOLT_READING(VOLT_READING), .VOLT_LOW(VOLT_LOW), .VOLT_HIGH(VOLT_HIGH), .TEMP_READING(TEMP_READING),
  .TEMP_LOW(TEMP_LOW), .TACH_COUNT(TACH_COUNT), .TACH_MIN(TACH_MIN), .PWM_OFF(PWM_OFF),
  .DIODE_FAULT(DIODE_FAULT), .LIMIT_ALERT(LIMIT_ALERT));
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the limit status flag block, register calls over AHB-Lite
// assumes the slave's HREADYOUT is the bus's HREADY and MCLK runs at 200 MHz
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lsfl_pkg::*;
  // byte addresses are four times the index
  localparam logic [31:0] A_CFG = {22'h0, LSFL_IDX_CFG1, 2'b00};
  localparam logic [31:0] A_S1 = {22'h0, LSFL_IDX_STAT1, 2'b00};
  localparam logic [31:0] A_S2 = {22'h0, LSFL_IDX_STAT2, 2'b00};
  localparam logic [31:0] A_MODE = {22'h0, LSFL_IDX_MODE, 2'b00};
  // voltage walk: boundary, high, back, just above low, low, back
  localparam logic [7:0] VSEQ [9] = '{8'hf0, 8'hf1, 8'hf1, 8'h80, 8'h80, 8'h11, 8'h10, 8'h80, 8'h80};
  localparam bit VEXP [9] = '{0, 1, 1, 1, 0, 0, 1, 1, 0};
  // -1 is in range only when compared signed
  localparam logic [7:0] TSEQ [4] = '{8'hff, 8'h81, 8'h00, 8'h00};
  localparam bit TEXP [4] = '{0, 1, 1, 0};
  // overtemp: above limit, inside hysteresis, below it
  localparam logic [7:0] OSEQ [5] = '{8'h60, 8'h4c, 8'h4c, 8'h4a, 8'h4a};
  localparam bit OEXP [5] = '{1, 1, 1, 1, 0};
  logic MCLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, THERMAL_LIMIT_PIN_TIMER_OVER, GENERAL_IO_SIX_IN;
  logic GENERAL_IO_SIX_OUT, GENERAL_IO_SIX_OE, FAN_FULL_DUTY, LIMIT_ALERT;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0] HTRANS, DIODE_FAULT;
  logic [2:0] HSIZE, PWM_OFF;
  logic [4:0][7:0] VOLT_READING, VOLT_LOW, VOLT_HIGH;
  logic [2:0][7:0] TEMP_READING, TEMP_LOW, TEMP_HIGH, TEMP_THERMAL_LIMIT_PIN_LIMIT;
  logic [7:0] THERMAL_HYSTERESIS;
  logic [3:0][15:0] TACH_COUNT, TACH_MIN;
  logic [5:0] CORE_VOLTAGE_CODE;
  logic [31:0] b;
  int n_errors, check_count;
  lsfl_top i_lsfl_top (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .VOLT_READING(VOLT_READING), .VOLT_LOW(VOLT_LOW), .VOLT_HIGH(VOLT_HIGH), .TEMP_READING(TEMP_READING),
    .TEMP_LOW(TEMP_LOW), .TEMP_HIGH(TEMP_HIGH), .TEMP_THERMAL_LIMIT_PIN_LIMIT(TEMP_THERMAL_LIMIT_PIN_LIMIT),
    .THERMAL_HYSTERESIS(THERMAL_HYSTERESIS), .TACH_COUNT(TACH_COUNT), .TACH_MIN(TACH_MIN), .PWM_OFF(PWM_OFF),
    .THERMAL_LIMIT_PIN_TIMER_OVER(THERMAL_LIMIT_PIN_TIMER_OVER), .DIODE_FAULT(DIODE_FAULT), .CORE_VOLTAGE_CODE(CORE_VOLTAGE_CODE),
    .GENERAL_IO_SIX_IN(GENERAL_IO_SIX_IN), .GENERAL_IO_SIX_OUT(GENERAL_IO_SIX_OUT),
    .GENERAL_IO_SIX_OE(GENERAL_IO_SIX_OE), .FAN_FULL_DUTY(FAN_FULL_DUTY), .LIMIT_ALERT(LIMIT_ALERT));
  // 5 ns period
  always #2.5 MCLK = ~MCLK;
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 20);
    if (HREADYOUT !== 1'b1) begin
      n_errors++;
      $display("BAD t=%0t slave never ready", $time);
      tally_and_finish();
    end
  endtask
  // one single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= addr;
    HWRITE <= wr;
    wait_ready();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    wait_ready();
    rd = HRDATA;
  endtask
  task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
    logic [31:0] r;
    bus(1'b1, addr, wd, r);
  endtask
  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, addr, 32'h0, r);
    chk(r, exp);
  endtask
  // raise or drop one status-two condition; one edge lets it settle
  task automatic set_cond(input int k, input bit on);
    if (k < 4) TACH_COUNT[k] <= on ? 16'h1001 : 16'h1000;
    else if (k < 6) DIODE_FAULT[k-4] <= on;
    else VOLT_READING[4] <= on ? 8'hf1 : 8'h80;
    @(posedge MCLK);
  endtask
  initial begin
    MCLK = 1'b0; RST = 1'b1; HSEL = 1'b0; HADDR = 32'h0; HTRANS = 2'b00; HWRITE = 1'b0; HSIZE = 3'h2;
    HWDATA = 32'h0; VOLT_READING = {5{8'h80}}; VOLT_LOW = {5{8'h10}}; VOLT_HIGH = {5{8'hf0}};
    TEMP_READING = '0; TEMP_LOW = {3{8'h81}}; TEMP_HIGH = {3{8'h7f}}; TEMP_THERMAL_LIMIT_PIN_LIMIT = {3{8'h50}};
    THERMAL_HYSTERESIS = 8'h05; TACH_COUNT = '0; TACH_MIN = {4{16'h1000}}; PWM_OFF = 3'h0;
    THERMAL_LIMIT_PIN_TIMER_OVER = 1'b0; DIODE_FAULT = 2'h0; CORE_VOLTAGE_CODE = 6'h0; GENERAL_IO_SIX_IN = 1'b0;
    n_errors = 0; check_count = 0;
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    rd_chk(A_S1, 32'(LSFL_STAT_RST));
    rd_chk(A_S2, 32'(LSFL_STAT_RST));
    rd_chk(A_CFG, 32'(LSFL_CFG1_RST));
    chk(32'(FAN_FULL_DUTY), 32'h1);
    wr(A_S1, 32'hff);
    wr(A_S2, 32'hff);
    rd_chk(A_S1, 32'h0);
    rd_chk(A_S2, 32'h0);
    rd_chk(32'h3fc, 32'h0);
    $display("test reset finished");
    wr(A_CFG, 32'h03);
    rd_chk(A_CFG, 32'h07);
    chk(32'(FAN_FULL_DUTY), 32'h0);
    wr(A_CFG, 32'h52);
    rd_chk(A_CFG, 32'h06);
    chk(32'(FAN_FULL_DUTY), 32'h1);
    $display("test config finished");
    for (int c = 0; c < 4; c++) begin
      b = 32'h1 << c;
      for (int i = 0; i < 9; i++) begin
        VOLT_READING[c] <= VSEQ[i];
        @(posedge MCLK);
        rd_chk(A_S1, VEXP[i] ? b : 32'h0);
      end
    end
    for (int c = 0; c < 3; c++) begin
      b = 32'h10 << c;
      for (int i = 0; i < 4; i++) begin
        TEMP_READING[c] <= TSEQ[i];
        @(posedge MCLK);
        rd_chk(A_S1, TEXP[i] ? b : 32'h0);
      end
    end
    $display("test status one finished");
    for (int k = 0; k < 7; k++) begin
      b = (k == 6) ? 32'h1 : 32'h1 << (k + 2);
      if (k < 4) begin
        PWM_OFF[(k == 3) ? 2 : k] <= 1'b1;
        set_cond(k, 1'b1);
        rd_chk(A_S2, 32'h0);
        PWM_OFF <= 3'h0;
      end
      set_cond(k, 1'b1);
      rd_chk(A_S2, b);
      rd_chk(A_S1, 32'h80);
      set_cond(k, 1'b0);
      rd_chk(A_S2, b);
      rd_chk(A_S1, 32'h0);
      rd_chk(A_S2, 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      TEMP_READING[1] <= OSEQ[i];
      @(posedge MCLK);
      rd_chk(A_S2, OEXP[i] ? 32'h2 : 32'h0);
    end
    $display("test status two finished");
    wr(A_MODE, 32'h1);
    THERMAL_LIMIT_PIN_TIMER_OVER <= 1'b1;
    @(posedge MCLK);
    rd_chk(A_S1, 32'h1);
    THERMAL_LIMIT_PIN_TIMER_OVER <= 1'b0;
    @(posedge MCLK);
    rd_chk(A_S1, 32'h1);
    rd_chk(A_S1, 32'h0);
    wr(A_MODE, 32'h2);
    CORE_VOLTAGE_CODE <= 6'h15;
    repeat (2 * LSFL_CODE_WIN_CYC + 4) @(posedge MCLK);
    chk(32'(LIMIT_ALERT), 32'h1);
    rd_chk(A_S2, 32'h1);
    rd_chk(A_S2, 32'h0);
    @(posedge MCLK);
    chk(32'(LIMIT_ALERT), 32'h0);
    $display("test pin modes finished");
    wr(A_MODE, 32'h4);
    wr(A_S2, 32'h20);
    // the output flop loads one edge after the level register; look after it has settled
    repeat (2) @(posedge MCLK);
    chk({30'h0, GENERAL_IO_SIX_OE, GENERAL_IO_SIX_OUT}, 32'h3);
    rd_chk(A_S2, 32'h20);
    wr(A_MODE, 32'h8);
    GENERAL_IO_SIX_IN <= 1'b1;
    @(posedge MCLK);
    rd_chk(A_S2, 32'h20);
    chk(32'(GENERAL_IO_SIX_OE), 32'h0);
    wr(A_MODE, 32'hc);
    THERMAL_LIMIT_PIN_TIMER_OVER <= 1'b1;
    @(posedge MCLK);
    rd_chk(A_S2, 32'h20);
    THERMAL_LIMIT_PIN_TIMER_OVER <= 1'b0;
    @(posedge MCLK);
    rd_chk(A_S2, 32'h20);
    rd_chk(A_S2, 32'h0);
    $display("test multi-function pin finished");
    tally_and_finish();
  end
endmodule
`default_nettype wire
